// [verilog/ptt_pkg.sv]
// Purpose: constants for the periodic tick timer
// Assumes: AXI4-Lite, 32-bit data, word-aligned registers
// Notes:   period register stores period minus one (24 bits)
`default_nettype none
package ptt_pkg;
   localparam int          PTT_CNT_W        = 24;
   localparam logic [7:0]  PTT_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  PTT_OFS_RELOAD   = 8'h04;
   localparam logic [7:0]  PTT_OFS_CURRENT  = 8'h08;
   localparam logic [7:0]  PTT_OFS_STATUS   = 8'h0C;
   localparam int          PTT_CTRL_ENABLE  = 0;
   localparam int          PTT_CTRL_INTEN   = 1;
   localparam int          PTT_STAT_PEND    = 0;
   localparam int          PTT_STAT_WRAP    = 1;
   localparam logic [23:0] PTT_RELOAD_RESET = 24'h000000;
   localparam logic [23:0] PTT_COUNT_RESET  = 24'h000000;
   localparam logic [1:0]  PTT_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  PTT_RESP_SLVERR  = 2'h2;
endpackage
`default_nettype wire

// [verilog/ptt_timer.sv]
// Purpose: periodic down-counter raising a tick interrupt, AXI4-Lite slave
// Assumes: single clock aclk, synchronous active-low aresetn, ce freezes state
// Notes:   write response and read data each come one cycle after acceptance
`default_nettype none
module ptt_timer
   import ptt_pkg::*;
(
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // interrupt controller side
   input  wire logic        handler_entry,
   output logic             tick_irq
);

   logic                 enable;
   logic                 int_enable;
   logic [PTT_CNT_W-1:0] tick_period_value;
   logic [PTT_CNT_W-1:0] count;
   logic                 pending;
   logic                 wrap_seen;
   logic                 aw_held;
   logic [7:0]           aw_addr;
   logic                 w_held;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;

   function automatic logic known_ofs(input logic [7:0] a);
      return a == PTT_OFS_CTRL || a == PTT_OFS_RELOAD ||
             a == PTT_OFS_CURRENT || a == PTT_OFS_STATUS;
   endfunction

   // write path: address and data captured independently
   wire        aw_take   = s_axi_awvalid && s_axi_awready;
   wire        w_take    = s_axi_wvalid && s_axi_wready;
   wire        aw_have   = aw_held || aw_take;
   wire        w_have    = w_held || w_take;
   wire [7:0]  wr_addr   = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data   = w_held ? w_data : s_axi_wdata;
   wire [3:0]  wr_strb   = w_held ? w_strb : s_axi_wstrb;
   wire        wr_fire   = ce && aw_have && w_have && !s_axi_bvalid;
   wire        wr_ctrl   = wr_fire && wr_addr == PTT_OFS_CTRL && wr_strb[0];
   wire        wr_reload = wr_fire && wr_addr == PTT_OFS_RELOAD;
   wire        wr_cur    = wr_fire && wr_addr == PTT_OFS_CURRENT;
   wire        wr_stat   = wr_fire && wr_addr == PTT_OFS_STATUS && wr_strb[0];

   assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;

   // counter datapath
   wire at_zero = count == '0;
   wire wrap    = enable && at_zero;
   wire tick    = wrap && int_enable;

   logic [PTT_CNT_W-1:0] next_count;
   always_comb begin
      next_count = count;
      if (wr_cur)
         next_count = '0;
      else if (enable) begin
         if (at_zero)
            next_count = tick_period_value;
         else
            next_count = count - 1'b1;
      end
   end

   // merged period byte write
   logic [PTT_CNT_W-1:0] next_period;
   always_comb begin
      next_period = tick_period_value;
      for (int i = 0; i < 3; i++) begin
         if (wr_strb[i])
            next_period[i*8 +: 8] = wr_data[i*8 +: 8];
      end
   end

   // read mux
   wire [31:0] rd_word =
      (s_axi_araddr == PTT_OFS_CTRL)    ? {30'h0, int_enable, enable} :
      (s_axi_araddr == PTT_OFS_RELOAD)  ? {8'h00, tick_period_value} :
      (s_axi_araddr == PTT_OFS_CURRENT) ? {8'h00, count} :
      (s_axi_araddr == PTT_OFS_STATUS)  ? {30'h0, wrap_seen, pending} : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable            <= 1'b0;
         int_enable        <= 1'b0;
         tick_period_value <= PTT_RELOAD_RESET;
         count             <= PTT_COUNT_RESET;
         pending           <= 1'b0;
         wrap_seen         <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl) begin
            enable     <= wr_data[PTT_CTRL_ENABLE];
            int_enable <= wr_data[PTT_CTRL_INTEN];
         end
         if (wr_reload)
            tick_period_value <= next_period;
         count <= next_count;
         // set wins over the handler clear
         if (tick)
            pending <= 1'b1;
         else if (handler_entry)
            pending <= 1'b0;
         if (wrap)
            wrap_seen <= 1'b1;
         else if (wr_stat && wr_data[PTT_STAT_WRAP])
            wrap_seen <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         aw_addr      <= 8'h00;
         w_held       <= 1'b0;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= PTT_RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_ofs(wr_addr) ? PTT_RESP_OKAY : PTT_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
               w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= PTT_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= known_ofs(s_axi_araddr) ? PTT_RESP_OKAY : PTT_RESP_SLVERR;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   assign tick_irq = pending;

endmodule
`default_nettype wire

// [test/ptt_timer_assertions.sv]
// Purpose: port-level checks for ptt_timer
// Assumes: bound to the ptt_timer top module
// Notes:   the count is internal, so checks stay on handshakes and the tick
`default_nettype none
module ptt_checker (
   input wire logic aclk, aresetn, ce, s_axi_awready, s_axi_bvalid, s_axi_bready,
   input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready, tick_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rhs;
      s_axi_rvalid && s_axi_rready;
   endsequence
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stuck");
   a_rvalid_drops: assert property (s_rhs |=> !s_axi_rvalid)
      else $error("rvalid stuck");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken during response");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   a_ce_blocks: assert property (!ce |-> !s_axi_awready && !s_axi_arready)
      else $error("ready while frozen");
   a_tick_needs_ce: assert property ($rose(tick_irq) |-> $past(ce))
      else $error("tick rose while frozen");
endmodule
bind ptt_timer ptt_checker i_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .tick_irq(tick_irq));
`default_nettype wire

// [test/ptt_timer_tb.sv]
// Purpose: self-checking bench for ptt_timer
// Assumes: axi4-lite master tasks, handler_entry mostly held high
// Notes:   with handler_entry high the tick shows as one-cycle pulses
`default_nettype none
module ptt_timer_tb;
   import ptt_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 0, aresetn = 0, ce = 1, awv = 0, wv = 0, bry = 0;
   logic        arv = 0, rry = 0, hen = 1, awr, wrd, arr, bv, rv, irq;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, v, c;
   logic [3:0]  ws = 4'hF;
   logic [1:0]  br, rr, rs, bs;
   int          err_total = 0, tests_run = 0, cyc = 0, n;
   ptt_timer i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .handler_entry(hen), .tick_irq(irq));
   initial forever #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         test_done;
      end
   end
   task chk(string nm, logic [31:0] s, logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      @(posedge aclk);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (bv !== 1'b1);
      bs = br;
      bry <= 0;
   endtask
   task rd(logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      ara <= a; arv <= 1; rry <= 1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end while (rv !== 1'b1);
      d = rdat; rs = rr; rry <= 0;
   endtask
   task t_regs;
      rd(PTT_OFS_RELOAD, v); chk("reload reset", v, 0);
      wr(PTT_OFS_RELOAD, 32'hFFABCDEF); rd(PTT_OFS_RELOAD, v);
      chk("reload 24b", v, 32'h00ABCDEF);
      rd(8'h10, v); chk("unmapped", rs, PTT_RESP_SLVERR);
      wr(8'h10, 32'h1); chk("unmapped wr", bs, PTT_RESP_SLVERR);
      wr(PTT_OFS_CTRL, 0); chk("ctrl wr", bs, PTT_RESP_OKAY);
      $display("t_regs done");
   endtask
   task t_tick;
      wr(PTT_OFS_RELOAD, 4); wr(PTT_OFS_CURRENT, 0); wr(PTT_OFS_CTRL, 3);
      do @(posedge aclk); while (!irq);
      n = 0;
      do begin @(posedge aclk); n++; end while (!irq);
      chk("period", n, 5);
      rd(PTT_OFS_CURRENT, v); chk("range", v <= 4, 1);
      rd(PTT_OFS_STATUS, v); chk("wrap seen", v[PTT_STAT_WRAP], 1);
      @(posedge aclk) hen <= 0;
      repeat (8) @(posedge aclk);
      chk("pending", irq, 1);
      wr(PTT_OFS_CTRL, 1);
      @(posedge aclk) hen <= 1;
      @(posedge aclk) hen <= 0;
      repeat (12) @(posedge aclk);
      chk("gated", irq, 0);
      hen <= 1;
      $display("t_tick done");
   endtask
   task t_stop;
      wr(PTT_OFS_RELOAD, 32'hFF); wr(PTT_OFS_CURRENT, 0); wr(PTT_OFS_CTRL, 1);
      repeat (10) @(posedge aclk);
      wr(PTT_OFS_CTRL, 0); rd(PTT_OFS_CURRENT, c);
      @(posedge aclk) ce <= 0;
      repeat (3) @(posedge aclk);
      ce <= 1;
      rd(PTT_OFS_CURRENT, v); chk("halted", v, c);
      wr(PTT_OFS_RELOAD, 32'h0F); wr(PTT_OFS_CTRL, 1); rd(PTT_OFS_CURRENT, v);
      chk("resume", v < c && v > 32'h0F, 1);
      wr(PTT_OFS_CURRENT, 32'h1234); rd(PTT_OFS_CURRENT, v);
      chk("forced", v <= 32'h0F, 1);
      $display("t_stop done");
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_tick;
      t_stop;
      test_done;
   end
endmodule
`default_nettype wire
